// File: rtl/mat_table.v
`timescale 1ns/1ps
`include "mat_map.vh"

// Summary of operation
// - a dynamic entry is removed once its age reaches the age time, which is 300 s after reset.
// - the age time is held in whole seconds and writes are kept within 10 to 1000000.
// - with aging disabled no dynamic entry is ever removed for age.
// - in auto mode a frame with an unknown source station address inserts a dynamic entry if a free entry exists.
// - in disabled mode a port never creates entries from received frames.
// - in secure mode only frames matching a static entry pass; others drop and nothing is learned.
// - an internal function may own a port's mode, and user mode writes to it are then blocked.
// - at most 64 static entries are held and adds beyond that are refused.
// - the 64 limit counts static entries of the whole stack, not this switch alone.
// - ordered reads return entries ascending by vlan id, then mac address.
// - every entry carries a static/dynamic flag, mac, vlan and port mask, readable by management.
// - a lookup returns the exact key match or else the closest following entry.
// - a get-next past the last entry reports end of table.
// - a static entry marked for deletion stays until the next save and is removed by it.
module mat_table #(
    parameter AW          = 7,
    parameter PORTS       = 12,
    parameter PW          = 4,
    parameter TICK_CYCLES = `MAT_TICK_CYCLES
) (
    // clock and reset
    input  wire                    clock,
    input  wire                    sys_rst,
    // aging configuration
    input  wire                    age_wr,
    input  wire [`MAT_AGE_W-1:0]   age_val,
    input  wire                    age_dis,
    output reg  [`MAT_AGE_W-1:0]   age_time,
    // learning mode control
    input  wire                    mode_wr,
    input  wire [PW-1:0]           mode_port,
    input  wire [1:0]              mode_val,
    input  wire [PORTS-1:0]        fn_own,
    input  wire                    fn_wr,
    input  wire [PW-1:0]           fn_port,
    input  wire [1:0]              fn_mode,
    output reg  [2*PORTS-1:0]      port_modes,
    output reg                     mode_blocked,
    // ingress learning request
    input  wire                    lrn_req,
    input  wire [PW-1:0]           lrn_port,
    input  wire [`MAT_VID_W-1:0]   lrn_vid,
    input  wire [`MAT_MAC_W-1:0]   source_station_address,
    output reg                     lrn_ack,
    output reg                     lrn_drop,
    // management command
    input  wire                    cmd_req,
    input  wire [2:0]              cmd_op,
    input  wire [`MAT_VID_W-1:0]   cmd_vid,
    input  wire [`MAT_MAC_W-1:0]   cmd_mac,
    input  wire [PORTS-1:0]        cmd_mask,
    input  wire [7:0]              peer_static,
    // management answer
    output reg                     rsp_valid,
    output reg                     rsp_err,
    output reg                     rsp_end,
    output reg                     rsp_static,
    output reg  [`MAT_VID_W-1:0]   rsp_vid,
    output reg  [`MAT_MAC_W-1:0]   rsp_mac,
    output reg  [PORTS-1:0]        rsp_mask,
    output reg  [7:0]              static_count
);

localparam DEPTH  = 1 << AW;
localparam S_IDLE = 2'h0;
localparam S_SCAN = 2'h1;
localparam S_ACT  = 2'h2;

// ----------------------------------------------------------------
// entry storage
// ----------------------------------------------------------------
reg [DEPTH-1:0]      e_val;
reg [DEPTH-1:0]      e_sta;
reg [DEPTH-1:0]      e_del;
reg [`MAT_KEY_W-1:0] e_key [0:DEPTH-1];
reg [PORTS-1:0]      e_msk [0:DEPTH-1];
reg [`MAT_AGE_W-1:0] e_age [0:DEPTH-1];

reg [1:0]            state;
reg [2:0]            op;
reg [AW-1:0]         idx;
reg [`MAT_KEY_W-1:0] cur_key;
reg [PORTS-1:0]      cur_msk;
reg [PW-1:0]         cur_port;
reg [26:0]           tick_cnt;
reg                  tick_pend;

wire          hit;
wire [AW-1:0] hit_idx;
wire          free_ok;
wire [AW-1:0] free_idx;
wire          best_ok;
wire [AW-1:0] best_idx;

function [PORTS-1:0] onehot;
    input [PW-1:0] p;
    begin
        onehot = {{(PORTS-1){1'b0}}, 1'b1} << p;
    end
endfunction

function [1:0] mode_of;
    input [2*PORTS-1:0] m;
    input [PW-1:0]      p;
    begin
        mode_of = m[2*p +: 2];
    end
endfunction

// stack-wide count, so a full peer blocks local adds as well
wire          at_limit = ({1'b0, static_count} + {1'b0, peer_static}) >= {1'b0, `MAT_STATIC_MAX};
wire [1:0]    lrn_mode = mode_of(port_modes, cur_port);
wire          last_idx = (idx == {AW{1'b1}});
wire          take_ok  = !rsp_valid && !lrn_ack;

mat_search #(
    .AW       (AW)
) u_search (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clr      (state == S_IDLE),
    .step     (state == S_SCAN),
    .strict   (op == `MAT_OP_NEXT),
    .key      (cur_key),
    .ent_idx  (idx),
    .ent_val  (e_val[idx]),
    .ent_key  (e_key[idx]),
    .hit      (hit),
    .hit_idx  (hit_idx),
    .free_ok  (free_ok),
    .free_idx (free_idx),
    .best_ok  (best_ok),
    .best_idx (best_idx)
);

// ----------------------------------------------------------------
// age time and mode registers
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        age_time     <= `MAT_AGE_DEF;
        port_modes   <= {2*PORTS{1'b0}};
        mode_blocked <= 1'b0;
    end else begin
        mode_blocked <= 1'b0;
        // out-of-range writes are clamped rather than ignored
        if (age_wr) begin
            if (age_val < `MAT_AGE_MIN)
                age_time <= `MAT_AGE_MIN;
            else if (age_val > `MAT_AGE_MAX)
                age_time <= `MAT_AGE_MAX;
            else
                age_time <= age_val;
        end
        // the owning function's write wins over a user write
        if (fn_wr && fn_own[fn_port]) begin
            port_modes[2*fn_port +: 2] <= fn_mode;
        end else if (mode_wr) begin
            if (fn_own[mode_port])
                mode_blocked <= 1'b1;
            else
                port_modes[2*mode_port +: 2] <= mode_val;
        end
    end
end

// ----------------------------------------------------------------
// one-second tick; a tick landing as the scan starts is kept
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        tick_cnt  <= 27'h0000000;
        tick_pend <= 1'b0;
    end else begin
        if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt  <= 27'h0000000;
            tick_pend <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 27'h0000001;
            if (state == S_IDLE)
                tick_pend <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// table engine: every operation scans all entries, then acts
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst) begin
        state        <= S_IDLE;
        op           <= `MAT_OP_ADD;
        idx          <= {AW{1'b0}};
        cur_key      <= {`MAT_KEY_W{1'b0}};
        cur_msk      <= {PORTS{1'b0}};
        cur_port     <= {PW{1'b0}};
        e_val        <= {DEPTH{1'b0}};
        e_sta        <= {DEPTH{1'b0}};
        e_del        <= {DEPTH{1'b0}};
        static_count <= 8'h00;
        lrn_ack      <= 1'b0;
        lrn_drop     <= 1'b0;
        rsp_valid    <= 1'b0;
        rsp_err      <= 1'b0;
        rsp_end      <= 1'b0;
        rsp_static   <= 1'b0;
        rsp_vid      <= {`MAT_VID_W{1'b0}};
        rsp_mac      <= {`MAT_MAC_W{1'b0}};
        rsp_mask     <= {PORTS{1'b0}};
    end else begin
        lrn_ack   <= 1'b0;
        rsp_valid <= 1'b0;
        case (state)
        S_IDLE: begin
            idx <= {AW{1'b0}};
            // aging first, then management, then ingress
            if (tick_pend && tick_cnt != TICK_CYCLES - 1) begin
                op    <= `MAT_OP_AGE;
                state <= S_SCAN;
            end else if (cmd_req && take_ok) begin
                op      <= cmd_op;
                cur_key <= {cmd_vid, cmd_mac};
                cur_msk <= cmd_mask;
                state   <= S_SCAN;
            end else if (lrn_req && take_ok) begin
                op       <= `MAT_OP_LEARN;
                cur_key  <= {lrn_vid, source_station_address};
                cur_port <= lrn_port;
                state    <= S_SCAN;
            end
        end
        S_SCAN: begin
            idx <= idx + {{(AW-1){1'b0}}, 1'b1};
            if (op == `MAT_OP_AGE && e_val[idx] && !e_sta[idx] && !age_dis) begin
                if (e_age[idx] + 20'h00001 >= age_time)
                    e_val[idx] <= 1'b0;
                else
                    e_age[idx] <= e_age[idx] + 20'h00001;
            end
            if (op == `MAT_OP_SAVE && e_val[idx] && e_sta[idx] && e_del[idx]) begin
                e_val[idx]   <= 1'b0;
                e_sta[idx]   <= 1'b0;
                e_del[idx]   <= 1'b0;
                static_count <= static_count - 8'h01;
            end
            if (last_idx)
                state <= S_ACT;
        end
        S_ACT: begin
            state    <= S_IDLE;
            rsp_err  <= 1'b0;
            rsp_end  <= 1'b0;
            lrn_drop <= 1'b0;
            case (op)
            `MAT_OP_ADD: begin
                rsp_valid <= 1'b1;
                if (hit && e_sta[hit_idx]) begin
                    e_msk[hit_idx] <= cur_msk;
                    e_del[hit_idx] <= 1'b0;
                end else if (at_limit || (!hit && !free_ok)) begin
                    rsp_err <= 1'b1;
                end else if (hit) begin
                    // a learned address becomes static in place
                    e_sta[hit_idx] <= 1'b1;
                    e_del[hit_idx] <= 1'b0;
                    e_msk[hit_idx] <= cur_msk;
                    static_count   <= static_count + 8'h01;
                end else begin
                    e_val[free_idx] <= 1'b1;
                    e_sta[free_idx] <= 1'b1;
                    e_del[free_idx] <= 1'b0;
                    e_key[free_idx] <= cur_key;
                    e_msk[free_idx] <= cur_msk;
                    e_age[free_idx] <= 20'h00000;
                    static_count    <= static_count + 8'h01;
                end
            end
            `MAT_OP_DEL: begin
                rsp_valid <= 1'b1;
                if (hit && e_sta[hit_idx])
                    e_del[hit_idx] <= 1'b1;
                else
                    rsp_err <= 1'b1;
            end
            `MAT_OP_SAVE: begin
                rsp_valid <= 1'b1;
            end
            `MAT_OP_LOOK, `MAT_OP_NEXT: begin
                rsp_valid <= 1'b1;
                if (best_ok) begin
                    rsp_static <= e_sta[best_idx];
                    rsp_vid    <= e_key[best_idx][`MAT_KEY_W-1:`MAT_MAC_W];
                    rsp_mac    <= e_key[best_idx][`MAT_MAC_W-1:0];
                    rsp_mask   <= e_msk[best_idx];
                end else begin
                    rsp_end <= 1'b1;
                end
            end
            `MAT_OP_LEARN: begin
                lrn_ack <= 1'b1;
                if (lrn_mode == `MAT_MODE_SECURE) begin
                    lrn_drop <= !(hit && e_sta[hit_idx]);
                end else if (lrn_mode == `MAT_MODE_AUTO) begin
                    if (hit && !e_sta[hit_idx]) begin
                        e_age[hit_idx] <= 20'h00000;
                        e_msk[hit_idx] <= onehot(cur_port);
                    end else if (!hit && free_ok) begin
                        // a full table simply skips learning
                        e_val[free_idx] <= 1'b1;
                        e_sta[free_idx] <= 1'b0;
                        e_del[free_idx] <= 1'b0;
                        e_key[free_idx] <= cur_key;
                        e_msk[free_idx] <= onehot(cur_port);
                        e_age[free_idx] <= 20'h00000;
                    end
                end
                // disabled mode falls through and learns nothing
            end
            default: begin
                rsp_valid <= 1'b0;
            end
            endcase
        end
        default: begin
            state <= S_IDLE;
        end
        endcase
    end
end

endmodule // mat_table

// File: rtl/mat_map.vh
`ifndef MAT_MAP_VH
`define MAT_MAP_VH

// ----------------------------------------------------------------
// learning modes, two bits per port
// ----------------------------------------------------------------
`define MAT_MODE_AUTO    2'h0
`define MAT_MODE_DISABLE 2'h1
`define MAT_MODE_SECURE  2'h2

// ----------------------------------------------------------------
// management operation codes
// ----------------------------------------------------------------
`define MAT_OP_ADD   3'h0
`define MAT_OP_DEL   3'h1
`define MAT_OP_SAVE  3'h2
`define MAT_OP_LOOK  3'h3
`define MAT_OP_NEXT  3'h4
`define MAT_OP_AGE   3'h5
`define MAT_OP_LEARN 3'h6

// ----------------------------------------------------------------
// key layout: vlan id above mac address
// ----------------------------------------------------------------
`define MAT_VID_W 12
`define MAT_MAC_W 48
`define MAT_KEY_W 60

// ----------------------------------------------------------------
// age time in seconds and static limit
// ----------------------------------------------------------------
`define MAT_AGE_W      20
`define MAT_AGE_DEF    20'h0012c
`define MAT_AGE_MIN    20'h0000a
`define MAT_AGE_MAX    20'hf4240
`define MAT_STATIC_MAX 8'h40

// ----------------------------------------------------------------
// one aging tick is one second at the switch clock
// ----------------------------------------------------------------
`define MAT_CLK_HZ      100000000
`define MAT_TICK_S      1
`define MAT_TICK_CYCLES (`MAT_TICK_S * `MAT_CLK_HZ)

`endif

// File: rtl/mat_search.v
`timescale 1ns/1ps
`include "mat_map.vh"

module mat_search #(
    parameter AW = 7
) (
    // clock and reset
    input  wire                  clock,
    input  wire                  sys_rst,
    // scan control
    input  wire                  clr,
    input  wire                  step,
    input  wire                  strict,
    input  wire [`MAT_KEY_W-1:0] key,
    // entry under scan
    input  wire [AW-1:0]         ent_idx,
    input  wire                  ent_val,
    input  wire [`MAT_KEY_W-1:0] ent_key,
    // results
    output reg                   hit,
    output reg  [AW-1:0]         hit_idx,
    output reg                   free_ok,
    output reg  [AW-1:0]         free_idx,
    output reg                   best_ok,
    output reg  [AW-1:0]         best_idx
);

reg [`MAT_KEY_W-1:0] best_key;

// ----------------------------------------------------------------
// ordering test on the vlan-then-mac key
// ----------------------------------------------------------------
function follows;
    input [`MAT_KEY_W-1:0] a;
    input [`MAT_KEY_W-1:0] b;
    input                  gt_only;
    begin
        follows = gt_only ? (a > b) : (a >= b);
    end
endfunction

wire cand = ent_val && follows(ent_key, key, strict);

// ----------------------------------------------------------------
// one entry per cycle; the smallest following key wins, so results
// come out in table order without keeping the storage sorted
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (sys_rst || clr) begin
        hit      <= 1'b0;
        hit_idx  <= {AW{1'b0}};
        free_ok  <= 1'b0;
        free_idx <= {AW{1'b0}};
        best_ok  <= 1'b0;
        best_idx <= {AW{1'b0}};
        best_key <= {`MAT_KEY_W{1'b0}};
    end else if (step) begin
        if (ent_val && ent_key == key) begin
            hit     <= 1'b1;
            hit_idx <= ent_idx;
        end
        if (!ent_val && !free_ok) begin
            free_ok  <= 1'b1;
            free_idx <= ent_idx;
        end
        if (cand && (!best_ok || ent_key < best_key)) begin
            best_ok  <= 1'b1;
            best_idx <= ent_idx;
            best_key <= ent_key;
        end
    end
end

endmodule // mat_search

// File: sim/mat_table_assertions.sv
`timescale 1ns/1ps
`include "mat_map.vh"

// --------
// port-level checker for the address table
// --------
module mat_table_assertions #(
    parameter PORTS = 12,
    parameter PW    = 4
) (
    // clock and reset
    input wire                  clock,
    input wire                  sys_rst,
    // configuration
    input wire                  age_wr,
    input wire [`MAT_AGE_W-1:0] age_val,
    input wire [`MAT_AGE_W-1:0] age_time,
    input wire                  mode_wr,
    input wire [PW-1:0]         mode_port,
    input wire [1:0]            mode_val,
    input wire [PORTS-1:0]      fn_own,
    input wire                  fn_wr,
    input wire [PW-1:0]         fn_port,
    input wire [1:0]            fn_mode,
    input wire [2*PORTS-1:0]    port_modes,
    input wire                  mode_blocked,
    // engine handshakes
    input wire                  lrn_req,
    input wire [PW-1:0]         lrn_port,
    input wire                  lrn_ack,
    input wire                  lrn_drop,
    input wire                  cmd_req,
    input wire                  rsp_valid,
    input wire [7:0]            peer_static,
    input wire [7:0]            static_count
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // request raised, then answered within 400 cycles, room for an ingress scan, an aging scan and its own scan
    sequence s_cmd_raised;
        $rose(cmd_req);
    endsequence
    sequence s_cmd_answer;
        ##[1:400] rsp_valid;
    endsequence

    a_age_default: assert property ($fell(sys_rst) |-> age_time == `MAT_AGE_DEF)
        else $error("age time not at default after reset");
    a_age_range: assert property (age_time >= `MAT_AGE_MIN && age_time <= `MAT_AGE_MAX)
        else $error("age time outside allowed range");
    a_age_write: assert property (age_wr && age_val >= `MAT_AGE_MIN && age_val <= `MAT_AGE_MAX
        |=> age_time == $past(age_val)) else $error("age write not taken");
    a_mode_blocked: assert property (mode_wr && !fn_wr && fn_own[mode_port]
        |=> mode_blocked && port_modes == $past(port_modes)) else $error("owned port mode changed");
    a_mode_user: assert property (mode_wr && !fn_wr && !fn_own[mode_port]
        |=> port_modes[2*$past(mode_port)+:2] == $past(mode_val)) else $error("user mode write lost");
    a_mode_owner: assert property (fn_wr && fn_own[fn_port]
        |=> port_modes[2*$past(fn_port)+:2] == $past(fn_mode)) else $error("owner mode write lost");
    a_learn_no_drop: assert property (lrn_ack && port_modes[2*lrn_port+:2] != `MAT_MODE_SECURE
        |-> !lrn_drop) else $error("frame dropped outside secure mode");
    a_static_room: assert property (static_count > $past(static_count)
        |-> ({1'b0, $past(static_count)} + {1'b0, $past(peer_static)}) < 9'h040)
        else $error("static entry added beyond stack limit");
    a_cmd_answer: assert property (s_cmd_raised |-> s_cmd_answer)
        else $error("command not answered in time");
    a_learn_answer: assert property ($rose(lrn_req) |-> ##[1:400] lrn_ack)
        else $error("learn request not answered in time");
endmodule // mat_table_assertions

bind mat_table mat_table_assertions #(.PORTS(PORTS), .PW(PW)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .age_wr(age_wr), .age_val(age_val), .age_time(age_time),
    .mode_wr(mode_wr), .mode_port(mode_port), .mode_val(mode_val), .fn_own(fn_own), .fn_wr(fn_wr),
    .fn_port(fn_port), .fn_mode(fn_mode), .port_modes(port_modes), .mode_blocked(mode_blocked),
    .lrn_req(lrn_req), .lrn_port(lrn_port), .lrn_ack(lrn_ack), .lrn_drop(lrn_drop), .cmd_req(cmd_req),
    .rsp_valid(rsp_valid), .peer_static(peer_static), .static_count(static_count)
);

// File: sim/mat_ingress.sv
`timescale 1ns/1ps

// --------
// ingress pipeline model: offers one source address per go pulse
// --------
module mat_ingress (
    // clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // frame to offer
    input  wire        go,
    input  wire [3:0]  port,
    input  wire [59:0] key,
    // learn handshake
    input  wire        lrn_ack,
    input  wire        lrn_drop,
    output reg         lrn_req = 1'b0,
    output reg  [3:0]  lrn_port = 4'h0,
    output reg  [11:0] lrn_vid = 12'h000,
    output reg  [47:0] source_station_address = 48'h000000000000,
    // outcome
    output reg         done = 1'b0,
    output reg         drop_seen = 1'b0
);
    // hold until the ack edge; released lines are inverted so stale values never look valid
    always @(posedge clock) begin
        done <= 1'b0;
        if (sys_rst) begin
            lrn_req <= 1'b0;
        end else if (go && !lrn_req) begin
            lrn_req <= 1'b1;
            lrn_port <= port;
            {lrn_vid, source_station_address} <= key;
        end else if (lrn_req && lrn_ack) begin
            lrn_req <= 1'b0;
            done <= 1'b1;
            drop_seen <= lrn_drop;
            lrn_port <= ~lrn_port;
            {lrn_vid, source_station_address} <= ~{lrn_vid, source_station_address};
        end
    end
endmodule // mat_ingress

// File: sim/mat_table_tb.sv
`timescale 1ns/1ps
`include "mat_map.vh"

module mat_table_tb;
    // --------
    // keys as {vid, mac}
    // --------
    localparam [59:0] KA = 60'h00100000000000a, KB = 60'h00200000000000b, KC = 60'h00300000000000c;
    localparam [59:0] KD = 60'h002000000000005, KE = 60'h001000000000001, KF = 60'h004000000000001;
    reg         clock, sys_rst, age_wr, age_dis, mode_wr, fn_wr, cmd_req, go;
    reg  [19:0] age_val;
    reg  [3:0]  mode_port, fn_port, gport;
    reg  [1:0]  mode_val, fn_mode;
    reg  [11:0] fn_own, cmd_vid, cmd_mask;
    reg  [47:0] cmd_mac;
    reg  [59:0] gkey;
    reg  [2:0]  cmd_op;
    reg  [7:0]  peer_static;
    wire [19:0] age_time;
    wire [23:0] port_modes;
    wire [11:0] lrn_vid, rsp_vid, rsp_mask;
    wire [47:0] ssa, rsp_mac;
    wire [3:0]  lrn_port;
    wire [7:0]  static_count;
    wire        mode_blocked, lrn_req, lrn_ack, lrn_drop, rsp_valid, rsp_err, rsp_end, rsp_static, done, drop_seen;
    integer     miscompares, checked;

    // aging tick shortened so that the ten-second minimum fits the run
    mat_table #(.TICK_CYCLES(200)) uut (
        .clock(clock), .sys_rst(sys_rst), .age_wr(age_wr), .age_val(age_val), .age_dis(age_dis),
        .age_time(age_time), .mode_wr(mode_wr), .mode_port(mode_port), .mode_val(mode_val), .fn_own(fn_own),
        .fn_wr(fn_wr), .fn_port(fn_port), .fn_mode(fn_mode), .port_modes(port_modes),
        .mode_blocked(mode_blocked), .lrn_req(lrn_req), .lrn_port(lrn_port), .lrn_vid(lrn_vid),
        .source_station_address(ssa), .lrn_ack(lrn_ack), .lrn_drop(lrn_drop), .cmd_req(cmd_req),
        .cmd_op(cmd_op), .cmd_vid(cmd_vid), .cmd_mac(cmd_mac), .cmd_mask(cmd_mask), .peer_static(peer_static),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_end(rsp_end), .rsp_static(rsp_static),
        .rsp_vid(rsp_vid), .rsp_mac(rsp_mac), .rsp_mask(rsp_mask), .static_count(static_count)
    );
    mat_ingress ing (
        .clock(clock), .sys_rst(sys_rst), .go(go), .port(gport), .key(gkey), .lrn_ack(lrn_ack),
        .lrn_drop(lrn_drop), .lrn_req(lrn_req), .lrn_port(lrn_port), .lrn_vid(lrn_vid),
        .source_station_address(ssa), .done(done), .drop_seen(drop_seen)
    );

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // --------
    // helpers
    // --------
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [63:0] got, input [63:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // bounded wait on a handshake level; running out closes the run
    task wait_hi(inout integer n);
        begin
            n = 0;
            while (n == 0 || ((cmd_req ? rsp_valid : done) !== 1'b1 && n < 600)) begin
                @(posedge clock);
                #1 n = n + 1;
            end
            if (n >= 600) begin
                miscompares = miscompares + 1;
                summarize;
            end
        end
    endtask
    task setage(input [19:0] v);
        begin
            @(posedge clock);
            age_wr <= 1'b1;
            age_val <= v;
            @(posedge clock);
            age_wr <= 1'b0;
            @(posedge clock);
            #1;
        end
    endtask
    // owner write when f is set, user write otherwise
    task setm(input f, input [3:0] p, input [1:0] v);
        begin
            @(posedge clock);
            if (f) {fn_wr, fn_port, fn_mode} <= {1'b1, p, v};
            else {mode_wr, mode_port, mode_val} <= {1'b1, p, v};
            @(posedge clock);
            fn_wr <= 1'b0;
            mode_wr <= 1'b0;
            @(posedge clock);
            #1;
        end
    endtask
    // request held until answered, released the next cycle, one idle cycle after
    task cmd(input [2:0] op, input [59:0] k, input [11:0] m);
        integer n;
        begin
            @(posedge clock);
            {cmd_req, cmd_op, cmd_vid, cmd_mac, cmd_mask} <= {1'b1, op, k, m};
            #1 wait_hi(n);
            @(posedge clock);
            cmd_req <= 1'b0;
            @(posedge clock);
            #1;
        end
    endtask
    task lk(input [2:0] op, input [59:0] k, input [60:0] exp);
        begin
            cmd(op, k, 12'h000);
            chk({rsp_end, rsp_static, rsp_vid, rsp_mac}, {1'b0, exp});
        end
    endtask
    task learn(input [3:0] p, input [59:0] k);
        integer n;
        begin
            @(posedge clock);
            {go, gport, gkey} <= {1'b1, p, k};
            @(posedge clock);
            go <= 1'b0;
            #1 wait_hi(n);
        end
    endtask

    // --------
    // main sequence
    // --------
    initial begin
        miscompares = 0;
        checked = 0;
        {sys_rst, age_dis, age_wr, mode_wr, fn_wr, cmd_req, go} = 7'h60;
        {age_val, mode_port, fn_port, gport, mode_val, fn_mode, fn_own} = 0;
        {cmd_op, cmd_vid, cmd_mac, cmd_mask, gkey, peer_static} = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        fn_own <= 12'h008;
        @(posedge clock);
        #1 chk(age_time, 20'h0012c);
        chk(port_modes, 24'h000000);
        setage(20'h0000a); chk(age_time, `MAT_AGE_MIN);
        setage(20'hf4240); chk(age_time, `MAT_AGE_MAX);
        setage(20'h0000a);
        setm(1'b0, 4'h1, `MAT_MODE_DISABLE); chk(port_modes[3:2], `MAT_MODE_DISABLE);
        setm(1'b0, 4'h3, `MAT_MODE_DISABLE); chk(port_modes[7:6], `MAT_MODE_AUTO);
        setm(1'b1, 4'h3, `MAT_MODE_SECURE); chk(port_modes[7:6], `MAT_MODE_SECURE);
        learn(4'h0, KA); chk(drop_seen, 1'b0);
        lk(`MAT_OP_LOOK, KA, {1'b0, KA}); chk(rsp_mask, 12'h001);
        learn(4'h1, KB); cmd(`MAT_OP_LOOK, KB, 12'h000); chk(rsp_end, 1'b1);
        learn(4'h3, KC); chk(drop_seen, 1'b1);
        cmd(`MAT_OP_LOOK, KC, 12'h000); chk(rsp_end, 1'b1);
        cmd(`MAT_OP_ADD, KC, 12'h008); cmd(`MAT_OP_ADD, KD, 12'h004); cmd(`MAT_OP_ADD, KE, 12'h002);
        cmd(`MAT_OP_SAVE, KE, 12'h000); chk(static_count, 8'h03);
        learn(4'h3, KC); chk(drop_seen, 1'b0);
        lk(`MAT_OP_LOOK, 60'h0, {1'b1, KE}); chk(rsp_mask, 12'h002);
        lk(`MAT_OP_NEXT, KE, {1'b0, KA});
        lk(`MAT_OP_NEXT, KA, {1'b1, KD});
        lk(`MAT_OP_NEXT, KD, {1'b1, KC});
        cmd(`MAT_OP_NEXT, KC, 12'h000); chk(rsp_end, 1'b1);
        cmd(`MAT_OP_DEL, KD, 12'h000); lk(`MAT_OP_LOOK, KD, {1'b1, KD});
        cmd(`MAT_OP_SAVE, KD, 12'h000); lk(`MAT_OP_LOOK, KD, {1'b1, KC});
        @(posedge clock) peer_static <= 8'h3e;
        cmd(`MAT_OP_ADD, KF, 12'h001); chk(rsp_err, 1'b1);
        @(posedge clock) peer_static <= 8'h3d;
        cmd(`MAT_OP_ADD, KF, 12'h001); chk(rsp_err, 1'b0);
        cmd(`MAT_OP_SAVE, KF, 12'h000); chk(static_count, 8'h03);
        repeat (3000) @(posedge clock);
        lk(`MAT_OP_LOOK, KA, {1'b0, KA});
        age_dis <= 1'b0;
        repeat (3000) @(posedge clock);
        lk(`MAT_OP_LOOK, 60'h001000000000002, {1'b1, KC});
        lk(`MAT_OP_LOOK, KE, {1'b1, KE});
        summarize;
    end
endmodule // mat_table_tb
